// ===== src/xbi_bus_if.v
// External memory and I/O bus interface of the signal processor.
`timescale 1ns/100ps
`include "xbi_defines.vh"
module xbi_bus_if #(
   parameter MC_DIV = `XBI_MC_DIV
) (
   // Clock, reset, enable
   input wire CLK_SYS,
   input wire SRST,
   input wire CE,
   // Core request port
   input wire REQ_VALID,
   input wire [1:0] REQ_SPACE,
   input wire REQ_WRITE,
   input wire REQ_INTERNAL,
   input wire REQ_INT_ACKNOWLEDGE,
   input wire [15:0] REQ_ADDR,
   input wire [15:0] REQ_WDATA,
   output reg REQ_BUSY,
   output reg REQ_DONE,
   output reg [15:0] REQ_RDATA,
   // Flag control from the core
   input wire FLAG_SET,
   input wire FLAG_CLR,
   // Bus pins
   input wire READY,
   input wire OUTPUT_FLOAT_N,
   input wire [15:0] DATA_IN,
   output reg [15:0] DATA_OUT,
   output reg DATA_OE,
   output reg [15:0] ADDR_OUT,
   output reg CTRL_OE,
   output reg MACHINE_CYCLE_CLOCK,
   output reg PROGRAM_SPACE_SELECT_N,
   output reg DATA_SPACE_SELECT_N,
   output reg IO_SPACE_SELECT_N,
   output reg BUS_STROBE_N,
   output reg READ_NOT_WRITE,
   output reg READ_SELECT_N,
   output reg WRITE_ENABLE_N,
   output reg GLOBAL_BUS_REQUEST,
   output reg INT_ACKNOWLEDGE,
   output reg EXT_FLAG_OUT
);
   // Bus cycle states.
   localparam [1:0] ST_IDLE = `XBI_ST_IDLE;
   localparam [1:0] ST_ADDR = `XBI_ST_ADDR;
   localparam [1:0] ST_WAIT = `XBI_ST_WAIT;
   localparam [1:0] ST_DONE = `XBI_ST_DONE;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg take_d;
   reg finish_d;
   reg [1:0] space_q;
   reg write_q;
   reg internal_q;
   reg int_acknowledge_q;
   reg [15:0] wdata_q;
   wire mc_clk;
   wire mc_rise;

   xbi_mc_clock #(
      .DIV(MC_DIV)
   ) u_mc (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CE),
      .mc_clk_q(mc_clk),
      .mc_rise_q(mc_rise)
   );

   // One-hot space decode keeps the selects mutually exclusive.
   function [2:0] sel_n;
      input [1:0] sp;
      input ext;
      begin
         sel_n = 3'h7;
         if (ext) begin
            if (sp == `XBI_SPACE_PROG) begin
               sel_n = 3'h6;
            end else if (sp == `XBI_SPACE_IO) begin
               sel_n = 3'h3;
            end else begin
               sel_n = 3'h5;
            end
         end
      end
   endfunction

   // Next-state logic is kept apart from the pin registers so each transition has one definition.
   always @* begin
      state_d = state_q;
      take_d = 1'b0;
      finish_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            // Requests are taken only at a machine cycle boundary.
            if (REQ_VALID && mc_rise) begin
               take_d = 1'b1;
               state_d = ST_ADDR;
            end
         end
         ST_ADDR: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            // Ready is sampled at each machine cycle end except on internal accesses; low costs one more cycle.
            if (mc_rise && (READY || internal_q)) begin
               finish_d = 1'b1;
               state_d = ST_DONE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         state_q <= ST_IDLE;
         space_q <= 2'h0;
         write_q <= 1'b0;
         internal_q <= 1'b0;
         int_acknowledge_q <= 1'b0;
         wdata_q <= 16'h0000;
         REQ_BUSY <= 1'b0;
         REQ_DONE <= 1'b0;
         REQ_RDATA <= 16'h0000;
         DATA_OUT <= 16'h0000;
         DATA_OE <= 1'b0;
         ADDR_OUT <= 16'h0000;
         CTRL_OE <= 1'b0;
         MACHINE_CYCLE_CLOCK <= 1'b0;
         PROGRAM_SPACE_SELECT_N <= `XBI_RST_STROBE_N;
         DATA_SPACE_SELECT_N <= `XBI_RST_STROBE_N;
         IO_SPACE_SELECT_N <= `XBI_RST_STROBE_N;
         BUS_STROBE_N <= `XBI_RST_STROBE_N;
         READ_NOT_WRITE <= `XBI_RST_RNW;
         READ_SELECT_N <= `XBI_RST_STROBE_N;
         WRITE_ENABLE_N <= `XBI_RST_STROBE_N;
         GLOBAL_BUS_REQUEST <= 1'b0;
         INT_ACKNOWLEDGE <= 1'b0;
         EXT_FLAG_OUT <= `XBI_RST_FLAG;
      end else if (CE) begin
         REQ_DONE <= 1'b0;
         state_q <= state_d;
         MACHINE_CYCLE_CLOCK <= mc_clk;
         // Float input removes the address and control drivers one clock later.
         // Limitation: DATA_OE follows the bus cycle only, so the pad ring must also qualify it with CTRL_OE.
         CTRL_OE <= OUTPUT_FLOAT_N;
         // Set takes precedence so a simultaneous set and clear leaves the flag high.
         if (FLAG_SET) begin
            EXT_FLAG_OUT <= 1'b1;
         end else if (FLAG_CLR) begin
            EXT_FLAG_OUT <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               if (take_d) begin
                  REQ_BUSY <= 1'b1;
                  space_q <= REQ_SPACE;
                  write_q <= REQ_WRITE;
                  internal_q <= REQ_INTERNAL && (REQ_SPACE == `XBI_SPACE_IO);
                  int_acknowledge_q <= REQ_INT_ACKNOWLEDGE;
                  wdata_q <= REQ_WDATA;
                  // Address, select and direction are latched once per access.
                  ADDR_OUT <= REQ_ADDR;
                  {IO_SPACE_SELECT_N, DATA_SPACE_SELECT_N, PROGRAM_SPACE_SELECT_N} <=
                     sel_n(REQ_SPACE, 1'b1);
                  READ_NOT_WRITE <= ~REQ_WRITE;
                  GLOBAL_BUS_REQUEST <= (REQ_SPACE == `XBI_SPACE_GLOBAL);
                  INT_ACKNOWLEDGE <= REQ_INT_ACKNOWLEDGE;
               end
            end
            ST_ADDR: begin
               // Internal register accesses show select and direction but no strobes.
               if (!internal_q) begin
                  BUS_STROBE_N <= 1'b0;
                  READ_SELECT_N <= write_q;
                  WRITE_ENABLE_N <= ~write_q;
               end
               DATA_OUT <= wdata_q;
               DATA_OE <= write_q;
            end
            ST_WAIT: begin
               if (finish_d) begin
                  REQ_RDATA <= DATA_IN;
                  BUS_STROBE_N <= 1'b1;
                  READ_SELECT_N <= 1'b1;
                  // Rising edge here is where the far side latches write data.
                  WRITE_ENABLE_N <= 1'b1;
               end
            end
            default: begin
               DATA_OE <= 1'b0;
               {IO_SPACE_SELECT_N, DATA_SPACE_SELECT_N, PROGRAM_SPACE_SELECT_N} <= sel_n(space_q, 1'b0);
               READ_NOT_WRITE <= 1'b1;
               GLOBAL_BUS_REQUEST <= 1'b0;
               INT_ACKNOWLEDGE <= 1'b0;
               REQ_BUSY <= 1'b0;
               REQ_DONE <= 1'b1;
            end
         endcase
      end
   end
endmodule // xbi_bus_if

// ===== src/xbi_defines.vh
// Constants for the external bus interface: encodings, timing and reset values.
`ifndef XBI_DEFINES_VH
`define XBI_DEFINES_VH
// Space codes on the request port.
`define XBI_SPACE_PROG 2'h0
`define XBI_SPACE_DATA 2'h1
`define XBI_SPACE_IO 2'h2
`define XBI_SPACE_GLOBAL 2'h3
// Machine cycle length in system clocks, and a derived half period.
`define XBI_MC_DIV 4
`define XBI_MC_HALF (`XBI_MC_DIV / 2)
// Reset values of the strobe, direction and flag outputs.
`define XBI_RST_STROBE_N 1'h1
`define XBI_RST_RNW 1'h1
`define XBI_RST_FLAG 1'h0
// Bus cycle states.
`define XBI_ST_IDLE 2'h0
`define XBI_ST_ADDR 2'h1
`define XBI_ST_WAIT 2'h2
`define XBI_ST_DONE 2'h3
`endif

// ===== src/xbi_mc_clock.v
// Machine cycle clock divider with a one-cycle pulse at each rising edge.
`timescale 1ns/100ps
`include "xbi_defines.vh"
module xbi_mc_clock #(
   parameter DIV = `XBI_MC_DIV
) (
   input wire clk,
   input wire srst,
   input wire ce,
   output reg mc_clk_q,
   output reg mc_rise_q
);
   reg [7:0] cnt_q;

   always @(posedge clk) begin
      if (srst) begin
         cnt_q <= 8'h00;
         mc_clk_q <= 1'b0;
         mc_rise_q <= 1'b0;
      end else if (ce) begin
         if (cnt_q == DIV[7:0] - 8'h01) begin
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
         // Each machine cycle begins on the rising edge of the divided clock.
         mc_rise_q <= (cnt_q == DIV[7:0] - 8'h01);
         mc_clk_q <= (cnt_q == DIV[7:0] - 8'h01) || (cnt_q < (DIV[7:0] >> 1) - 8'h01);
      end
   end
endmodule // xbi_mc_clock

// ===== verif/test_xbi_bus_if.sv
// Self-checking bench for the external bus interface.
`timescale 1ns/100ps
module test_xbi_bus_if;
   localparam int MC = 4;
   reg CLK_SYS = 1'h0, SRST = 1'h1, CE = 1'h1, REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_INTERNAL = 1'h0;
   reg REQ_INT_ACKNOWLEDGE = 1'h0, FLAG_SET = 1'h0, FLAG_CLR = 1'h0, OUTPUT_FLOAT_N = 1'h1;
   reg [1:0] REQ_SPACE = 2'h0;
   reg [3:0] waits = 4'h0;
   reg [15:0] REQ_ADDR = 16'h0000, REQ_WDATA = 16'h0000, rd;
   reg [7:0] seen;
   wire REQ_BUSY, REQ_DONE, READY, DATA_OE, CTRL_OE, MACHINE_CYCLE_CLOCK, PROGRAM_SPACE_SELECT_N;
   wire DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N, BUS_STROBE_N, READ_NOT_WRITE, READ_SELECT_N, WRITE_ENABLE_N;
   wire GLOBAL_BUS_REQUEST, INT_ACKNOWLEDGE, EXT_FLAG_OUT;
   wire [15:0] REQ_RDATA, DATA_IN, DATA_OUT, ADDR_OUT;
   int fail_count = 0, comparisons = 0, n, nb, nf;
   xbi_bus_if #(.MC_DIV(MC)) dut (.*);
   xbi_ext_mem mem (.clk(CLK_SYS), .strobe_n(BUS_STROBE_N), .rd_n(READ_SELECT_N), .we_n(WRITE_ENABLE_N),
      .addr(ADDR_OUT), .dout(DATA_OUT), .waits(waits), .ready(READY), .din(DATA_IN));
   always #20 CLK_SYS = ~CLK_SYS;
   task check(input [31:0] s, input [31:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task summarize;
      $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One whole access; seen gathers each space select, request, direction, bus strobe and acknowledge line that went active, and data drive.
   task automatic access(input [1:0] sp, input wr, input inl, input ik, input [15:0] a, input [15:0] d);
      @(negedge CLK_SYS);
      {REQ_SPACE, REQ_WRITE, REQ_INTERNAL, REQ_INT_ACKNOWLEDGE, REQ_ADDR, REQ_WDATA, REQ_VALID} = {sp, wr, inl, ik, a, d, 1'h1};
      seen = 8'h00;
      nb = 0;
      for (n = 0; n < 200 && REQ_DONE !== 1'h1; n++) begin
         @(negedge CLK_SYS);
         nb += REQ_BUSY;
         seen |= {~{PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N, ~GLOBAL_BUS_REQUEST,
            READ_NOT_WRITE, BUS_STROBE_N, ~INT_ACKNOWLEDGE}, DATA_OE};
      end
      if (n == 200) begin
         fail_count++;
         summarize();
      end
      REQ_VALID = 1'h0;
      rd = REQ_RDATA;
      check(seen[7:4], {sp == 2'h0, sp[0], sp == 2'h2, sp == 2'h3});
      check(seen[3:0], {wr, !inl, ik, wr});
   endtask
   task t_spaces;
      for (int s = 0; s < 4; s++) begin
         access(s[1:0], 1'h1, 1'h0, 1'h0, 16'h0010 + s[15:0], 16'hC3A0 + s[15:0]);
         access(s[1:0], 1'h0, 1'h0, 1'h0, 16'h0010 + s[15:0], 16'h0000);
         check(rd, 16'hC3A0 + s);
      end
      access(2'h0, 1'h0, 1'h0, 1'h1, 16'h0012, 16'h0000);
      check(rd, 16'hC3A2);
   endtask
   task t_wait;
      access(2'h1, 1'h0, 1'h0, 1'h0, 16'h0011, 16'h0000);
      nf = nb;
      waits = 4'h9;
      access(2'h3, 1'h1, 1'h0, 1'h0, 16'h0015, 16'h5A5A);
      access(2'h1, 1'h0, 1'h0, 1'h0, 16'h0015, 16'h0000);
      check(rd, 16'h5A5A);
      check((nb - nf) % MC, 0);
      check(nb > nf, 1);
   endtask
   task t_internal;
      // An internal write must still show direction and data drive, without bus strobe.
      access(2'h2, 1'h1, 1'h1, 1'h0, 16'h0003, 16'h1234);
      nf = nb;
      waits = 4'h0;
      access(2'h2, 1'h0, 1'h1, 1'h0, 16'h0003, 16'h0000);
      check(nb, nf);
   endtask
   task t_flag_float;
      {FLAG_SET, OUTPUT_FLOAT_N} = 2'h2;
      @(negedge CLK_SYS);
      check({EXT_FLAG_OUT, CTRL_OE}, 2'h2);
      {FLAG_SET, FLAG_CLR, OUTPUT_FLOAT_N} = 3'h3;
      @(negedge CLK_SYS);
      check({EXT_FLAG_OUT, CTRL_OE}, 2'h1);
      {FLAG_SET, FLAG_CLR} = 2'h3;
      @(negedge CLK_SYS);
      check(EXT_FLAG_OUT, 1);
      // A low clock enable must hold the flag against a pending clear.
      {CE, FLAG_SET} = 2'h0;
      @(negedge CLK_SYS);
      check(EXT_FLAG_OUT, 1);
      CE = 1'h1;
      @(negedge CLK_SYS);
      check(EXT_FLAG_OUT, 0);
      FLAG_CLR = 1'h0;
   endtask
   // The machine cycle clock must rise exactly twice in two machine cycles.
   task t_mcclk;
      rd[0] = MACHINE_CYCLE_CLOCK;
      nf = 0;
      for (n = 0; n < 2 * MC; n++) begin
         @(negedge CLK_SYS);
         nf += MACHINE_CYCLE_CLOCK && !rd[0];
         rd[0] = MACHINE_CYCLE_CLOCK;
      end
      check(nf, 2);
   endtask
   initial begin
      repeat (5) @(negedge CLK_SYS);
      SRST = 1'h0;
      check({PROGRAM_SPACE_SELECT_N, BUS_STROBE_N, READ_NOT_WRITE, REQ_BUSY, EXT_FLAG_OUT}, 5'h1C);
      t_spaces;
      t_wait;
      t_internal;
      t_flag_float;
      t_mcclk;
      summarize();
   end
endmodule // test_xbi_bus_if

// ===== verif/xbi_bus_if_chk.sv
// Protocol assertions on the external bus pins.
`timescale 1ns/100ps
module xbi_bus_if_chk (
   // Clock, reset, core side, and the ready and float input pins
   input wire CLK_SYS, input wire SRST, input wire CE, input wire REQ_BUSY, input wire REQ_INTERNAL,
   input wire [1:0] REQ_SPACE, input wire REQ_WRITE, input wire READY, input wire OUTPUT_FLOAT_N,
   // Bus pins
   input wire [15:0] ADDR_OUT, input wire CTRL_OE, input wire DATA_OE, input wire PROGRAM_SPACE_SELECT_N,
   input wire DATA_SPACE_SELECT_N, input wire IO_SPACE_SELECT_N, input wire BUS_STROBE_N,
   input wire READ_NOT_WRITE, input wire READ_SELECT_N, input wire WRITE_ENABLE_N, input wire GLOBAL_BUS_REQUEST
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);
   wire [2:0] sel_n = {PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N};
   AST_IO_SEL: assert property (!IO_SPACE_SELECT_N |-> REQ_BUSY && REQ_SPACE == 2'h2)
      else $error("io select");
   AST_RNW: assert property (!READ_NOT_WRITE |-> REQ_BUSY && REQ_WRITE) else $error("direction");
   AST_STROBE: assert property (!BUS_STROBE_N |-> REQ_BUSY && !REQ_INTERNAL) else $error("strobe");
   AST_RD_SEL: assert property (!READ_SELECT_N |-> !BUS_STROBE_N && READ_NOT_WRITE)
      else $error("read select");
   AST_WE: assert property (!WRITE_ENABLE_N |-> DATA_OE && !BUS_STROBE_N)
      else $error("write enable");
   AST_BUS_REQ: assert property (GLOBAL_BUS_REQUEST == (REQ_SPACE == 2'h3 && !DATA_SPACE_SELECT_N))
      else $error("bus request");
   AST_ONE_SPACE: assert property ($onehot0(~sel_n)) else $error("two selects");
   AST_HOLD: assert property (!BUS_STROBE_N && !READY
      |=> !BUS_STROBE_N && $stable({ADDR_OUT, sel_n})) else $error("wait cycle");
   AST_FLOAT: assert property (!OUTPUT_FLOAT_N && CE |=> !CTRL_OE) else $error("float");
   COV_WAIT_WRITE: cover property (!WRITE_ENABLE_N && !READY);
   COV_GLOBAL: cover property (GLOBAL_BUS_REQUEST);
   COV_FLOAT: cover property (!CTRL_OE);
endmodule // xbi_bus_if_chk
bind xbi_bus_if xbi_bus_if_chk u_chk (.*);

// ===== verif/xbi_ext_mem.sv
// External memory model with a set number of wait clocks.
`timescale 1ns/100ps
module xbi_ext_mem (
   input wire clk, input wire strobe_n, input wire rd_n, input wire we_n,
   input wire [15:0] addr, input wire [15:0] dout, input wire [3:0] waits,
   output wire ready, output wire [15:0] din
);
   reg [15:0] mem [0:15];
   reg [3:0] cnt_q;
   always @(posedge clk) cnt_q <= strobe_n ? 4'h0 : cnt_q + 4'h1;
   assign ready = cnt_q >= waits;
   // An idle bus shows the inverse, so a stale read cannot match by chance.
   assign din = rd_n ? ~mem[addr[3:0]] : mem[addr[3:0]];
   always @(posedge we_n) mem[addr[3:0]] <= dout;
endmodule // xbi_ext_mem
